// ===== shared/event_route_pkg.sv
package event_route_pkg;
    localparam int NUM_REGS = 4;
    localparam int NUM_INPUTS = 8;
    localparam int NUM_UNITS = 8;
    localparam int PTR_W = 3;
    localparam logic [31:0] ROUTE_CTRL_BASE = 32'h0000_0000;
    localparam int EVEN_PTR_LSB = 12;
    localparam int ODD_PTR_LSB = 28;
    localparam int EVEN_EN_BIT = 11;
    localparam int ODD_EN_BIT = 27;
    localparam logic [31:0] ROUTE_CTRL_MASK = 32'h7800_7800;
    localparam logic [31:0] ROUTE_CTRL_RESET = 32'h0000_0000;
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [2:0] HSIZE_WORD = 3'h2;

    typedef struct packed {
        logic [31:0] haddr;
        logic hwrite;
        logic [2:0] hsize;
        logic [1:0] htrans;
        logic hsel;
        logic hready;
    } ahb_req_s;
endpackage

// ===== rtl/event_trigger_routing.sv
// The address map and the AHB-Lite interface to the registers were decided locally.
`timescale 1ns/1ps

// one routed input: the enable bit gates the trigger, the pointer picks
// the gating unit; every pointer code names a unit, so no code is illegal
module route_slice
    import event_route_pkg::*;
#(
    parameter int UNITS = NUM_UNITS,
    parameter int PTR_BITS = PTR_W
) (
    input wire logic enable,
    input wire logic [PTR_BITS-1:0] pointer,
    input wire logic trigger,
    output logic [UNITS-1:0] line
);

    if (PTR_BITS < 1) begin : g_ptr_check
        $error("route_slice: pointer needs at least one bit");
    end

    // fewer units would leave some pointer codes with nowhere to go
    if (UNITS < (1 << PTR_BITS)) begin : g_units_check
        $error("route_slice: fewer gating units than pointer codes");
    end

    always_comb begin
        line = '0;
        if (enable) begin
            // bit index of the line is the selected unit number
            line[pointer] = trigger;
        end
    end
endmodule // route_slice

// one gating unit: it fires when any source routes to it in this cycle
module unit_merge
    import event_route_pkg::*;
#(
    parameter int SOURCES = NUM_INPUTS
) (
    input wire logic [SOURCES-1:0] column,
    output logic hit
);

    if (SOURCES < 1) begin : g_src_check
        $error("unit_merge: needs at least one source");
    end

    always_comb begin
        hit = |column;
    end
endmodule // unit_merge

// one control register and the pair of inputs it serves
module route_pair
    import event_route_pkg::*;
#(
    parameter int UNITS = NUM_UNITS
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic wr_en,
    input wire logic [31:0] wr_data,
    input wire logic [1:0] trigger,
    output logic [31:0] ctrl_reg,
    output logic [UNITS-1:0] even_line,
    output logic [UNITS-1:0] odd_line
);
    logic [PTR_W-1:0] even_ptr;
    logic [PTR_W-1:0] odd_ptr;
    logic even_en;
    logic odd_en;

    if (UNITS < (1 << PTR_W)) begin : g_units_check
        $error("route_pair: every pointer code needs a gating unit");
    end

    // reset clears both enables, so nothing is routed until software asks
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_reg <= ROUTE_CTRL_RESET;
        end else if (wr_en) begin
            ctrl_reg <= wr_data;
        end
    end

    assign even_ptr = ctrl_reg[EVEN_PTR_LSB +: PTR_W];
    assign even_en = ctrl_reg[EVEN_EN_BIT];
    assign odd_ptr = ctrl_reg[ODD_PTR_LSB +: PTR_W];
    assign odd_en = ctrl_reg[ODD_EN_BIT];

    route_slice #(
        .UNITS(UNITS),
        .PTR_BITS(PTR_W)
    ) route_slice_even (
        .enable(even_en),
        .pointer(even_ptr),
        .trigger(trigger[0]),
        .line(even_line)
    );

    route_slice #(
        .UNITS(UNITS),
        .PTR_BITS(PTR_W)
    ) route_slice_odd (
        .enable(odd_en),
        .pointer(odd_ptr),
        .trigger(trigger[1]),
        .line(odd_line)
    );
endmodule // route_pair

module event_trigger_routing
    import event_route_pkg::*;
#(
    parameter int REGS = NUM_REGS,
    parameter int UNITS = NUM_UNITS
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire ahb_req_s ahb_req,
    input wire logic [31:0] hwdata,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic [NUM_INPUTS-1:0] trigger_in,
    output logic [NUM_INPUTS-1:0][NUM_UNITS-1:0] routed_trigger_line,
    output logic [NUM_UNITS-1:0] unit_trigger
);
    // every field the control word keeps; the package mask must agree
    localparam logic [31:0] FIELD_MASK = 32'(
        (((1 << PTR_W) - 1) << EVEN_PTR_LSB) |
        (((1 << PTR_W) - 1) << ODD_PTR_LSB) |
        (1 << EVEN_EN_BIT) |
        (1 << ODD_EN_BIT));

    logic [31:0] ctrl_reg [REGS];
    logic wr_pend_reg;
    logic [1:0] wr_idx_reg;
    logic [REGS-1:0] wr_sel;
    logic [NUM_INPUTS-1:0][UNITS-1:0] line_next;
    logic [UNITS-1:0][NUM_INPUTS-1:0] column_next;
    logic [UNITS-1:0] unit_next;
    logic bus_phase;
    logic addr_hit;
    logic wr_hit;
    logic rd_hit;
    logic [1:0] addr_idx;
    logic [31:0] wr_data;
    logic fwd_hit;
    logic [31:0] rd_word;

    // the window decodes haddr[3:2], so it holds four registers at most
    if (REGS < 1 || REGS > 4) begin : g_regs_check
        $error("event_trigger_routing: one to four control registers");
    end

    if (2 * REGS != NUM_INPUTS) begin : g_inputs_check
        $error("event_trigger_routing: two inputs per register");
    end

    if (UNITS != NUM_UNITS) begin : g_units_check
        $error("event_trigger_routing: unit count must match the ports");
    end

    if (UNITS < (1 << PTR_W)) begin : g_codes_check
        $error("event_trigger_routing: every pointer code needs a unit");
    end

    if (EVEN_PTR_LSB + PTR_W > 32) begin : g_even_field_check
        $error("event_trigger_routing: even pointer leaves the word");
    end

    if (ODD_PTR_LSB + PTR_W > 32) begin : g_odd_field_check
        $error("event_trigger_routing: odd pointer leaves the word");
    end

    if (EVEN_EN_BIT >= EVEN_PTR_LSB &&
        EVEN_EN_BIT < EVEN_PTR_LSB + PTR_W) begin : g_even_en_check
        $error("event_trigger_routing: even enable inside its pointer");
    end

    if (ODD_EN_BIT >= ODD_PTR_LSB &&
        ODD_EN_BIT < ODD_PTR_LSB + PTR_W) begin : g_odd_en_check
        $error("event_trigger_routing: odd enable inside its pointer");
    end

    if (ROUTE_CTRL_MASK != FIELD_MASK) begin : g_mask_check
        $error("event_trigger_routing: stored bits must match the fields");
    end

    // address phase: only NONSEQ transfers inside the window, of any hsize
    assign bus_phase = ahb_req.hsel && ahb_req.hready &&
        ahb_req.htrans == HTRANS_NONSEQ;
    assign addr_idx = ahb_req.haddr[3:2];
    assign addr_hit = bus_phase &&
        ahb_req.haddr[31:4] == ROUTE_CTRL_BASE[31:4] &&
        int'(addr_idx) < REGS;
    assign wr_hit = addr_hit && ahb_req.hwrite;
    assign rd_hit = addr_hit && !ahb_req.hwrite;

    // unused bits are not stored so they read back as zero
    assign wr_data = hwdata & ROUTE_CTRL_MASK;

    // a read right behind a write to the same register sees the new word,
    // since the write only lands at the end of its data phase
    assign fwd_hit = wr_pend_reg && wr_idx_reg == addr_idx;
    assign rd_word = fwd_hit ? wr_data : ctrl_reg[addr_idx];

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            wr_pend_reg <= 1'b0;
        end else begin
            wr_pend_reg <= wr_hit;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            wr_idx_reg <= 2'h0;
        end else begin
            wr_idx_reg <= addr_idx;
        end
    end

    for (genvar r = 0; r < REGS; r++) begin : g_pair
        assign wr_sel[r] = wr_pend_reg && wr_idx_reg == 2'(r);

        route_pair #(
            .UNITS(UNITS)
        ) route_pair_r (
            .clk_sys(clk_sys),
            .rst_n(rst_n),
            .wr_en(wr_sel[r]),
            .wr_data(wr_data),
            .trigger(trigger_in[2*r +: 2]),
            .ctrl_reg(ctrl_reg[r]),
            .even_line(line_next[2*r]),
            .odd_line(line_next[2*r+1])
        );
    end

    for (genvar u = 0; u < UNITS; u++) begin : g_unit
        for (genvar s = 0; s < NUM_INPUTS; s++) begin : g_src
            assign column_next[u][s] = line_next[s][u];
        end

        unit_merge #(
            .SOURCES(NUM_INPUTS)
        ) unit_merge_col (
            .column(column_next[u]),
            .hit(unit_next[u])
        );
    end

    // read data registered at address phase; zero outside a mapped read
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            hrdata <= 32'h0000_0000;
        end else if (rd_hit) begin
            hrdata <= rd_word;
        end else begin
            hrdata <= 32'h0000_0000;
        end
    end

    // zero wait states: every transfer ends in its first data cycle
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            hreadyout <= 1'b1;
        end else begin
            hreadyout <= 1'b1;
        end
    end

    // never an error: unmapped reads return zero, unmapped writes vanish
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            hresp <= 1'b0;
        end else begin
            hresp <= 1'b0;
        end
    end

    // registered outputs: one cycle of latency from trigger_in
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            routed_trigger_line <= '0;
        end else begin
            routed_trigger_line <= line_next;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            unit_trigger <= '0;
        end else begin
            unit_trigger <= unit_next;
        end
    end
endmodule // event_trigger_routing

// ===== tb/event_route_checker.sv
`timescale 1ns/1ps
module event_route_checker
    import event_route_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire ahb_req_s ahb_req,
    input wire logic [31:0] hrdata,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic [NUM_INPUTS-1:0] trigger_in,
    input wire logic [NUM_INPUTS-1:0][NUM_UNITS-1:0] routed_trigger_line,
    input wire logic [NUM_UNITS-1:0] unit_trigger
);
    logic rd_phase;
    assign rd_phase = ahb_req.hsel && ahb_req.hready && !ahb_req.hwrite &&
        ahb_req.htrans == HTRANS_NONSEQ;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    sequence s_no_read;
        !rd_phase;
    endsequence
    sequence s_rdata_quiet;
        hrdata == 32'h0000_0000;
    endsequence
    a_ready_high: assert property (hreadyout)
        else $error("wait state inserted");
    a_resp_okay: assert property (!hresp)
        else $error("error response seen");
    a_rdata_zero: assert property (s_no_read |=> s_rdata_quiet)
        else $error("read data outside a read");
    for (genvar u = 0; u < NUM_UNITS; u++) begin : g_unit
        logic [NUM_INPUTS-1:0] col;
        for (genvar s = 0; s < NUM_INPUTS; s++) begin : g_col
            assign col[s] = routed_trigger_line[s][u];
        end
        a_unit_is_or: assert property (unit_trigger[u] == |col)
            else $error("unit differs from its lines");
    end
    for (genvar k = 0; k < NUM_INPUTS; k++) begin : g_src
        a_line_drops: assert property (!trigger_in[k] |=>
            routed_trigger_line[k] == '0) else $error("stale line");
        a_line_needs_trig: assert property (|routed_trigger_line[k]
            |-> $past(trigger_in[k])) else $error("line without trigger");
        a_line_one_unit: assert property (
            $onehot0(routed_trigger_line[k])) else $error("two units hit");
    end
endmodule // event_route_checker
bind event_trigger_routing event_route_checker event_route_checker_inst (
    .clk_sys(clk_sys), .rst_n(rst_n), .ahb_req(ahb_req), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .trigger_in(trigger_in),
    .routed_trigger_line(routed_trigger_line),
    .unit_trigger(unit_trigger));

// ===== tb/event_route_partner.sv
`timescale 1ns/1ps
module event_route_partner (
    input wire logic clk_sys,
    input wire logic [7:0] fire,
    output logic [7:0] trigger_in
);
    // edge stages hand a detected event over as a level, one cycle late
    always_ff @(posedge clk_sys) trigger_in <= fire;
endmodule // event_route_partner

// ===== tb/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    import event_route_pkg::*;
    logic clk_sys = 0, rst_n = 0, hreadyout, hresp;
    logic [31:0] hwdata = 0, hrdata, r, d;
    logic [7:0] fire = 0, trig, unit_trigger;
    logic [7:0][7:0] lines;
    ahb_req_s req = '0, ahb;
    int n_fail = 0, num_checks = 0, cyc = 0;
    assign ahb = {req[39:1], hreadyout};
    always #5 clk_sys = ~clk_sys;
    event_route_partner event_route_partner_inst (.clk_sys(clk_sys),
        .fire(fire), .trigger_in(trig));
    event_trigger_routing event_trigger_routing_inst (.clk_sys(clk_sys),
        .rst_n(rst_n), .ahb_req(ahb), .hwdata(hwdata), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .trigger_in(trig),
        .routed_trigger_line(lines), .unit_trigger(unit_trigger));
    task automatic xfer(input logic w, input logic [31:0] a, dat);
        req <= '{a, w, HSIZE_WORD, HTRANS_NONSEQ, 1'b1, 1'b0};
        do @(posedge clk_sys); while (hreadyout !== 1'b1);
        req.htrans <= 2'h0;
        hwdata <= dat;
        do @(posedge clk_sys); while (hreadyout !== 1'b1);
        r = hrdata;
        chk("hresp", 0, hresp);
    endtask
    task automatic chk(input string s, input logic [31:0] e, g);
        num_checks++;
        if (g !== e) begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", s, e, g);
        end
    endtask
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            n_fail++;
            give_verdict;
        end
    end
    initial begin
        repeat (3) @(posedge clk_sys);
        rst_n <= 1;
        for (int i = 0; i < NUM_REGS; i++) for (int c = 0; c < 8; c++) begin
            // odd enable only on odd codes, so disabled routing is seen too
            d = 32'((c << EVEN_PTR_LSB) | (1 << EVEN_EN_BIT) |
                ((7 - c) << ODD_PTR_LSB) | ((c & 1) << ODD_EN_BIT));
            xfer(1, 4 * i, d | 32'h1);
            fire <= 8'h03 << (2 * i);
            xfer(0, 4 * i, 0);
            chk("ctrl", d, r);
            repeat (2) @(posedge clk_sys);
            chk("even", 8'h01 << c, lines[2 * i]);
            chk("odd", (c & 1) << (7 - c), lines[2 * i + 1]);
            chk("unit", (1 << c) | ((c & 1) << (7 - c)),
                unit_trigger);
        end
        // pointers set but both enables clear: nothing may be routed
        xfer(1, 0, 32'h5000_5000);
        fire <= 8'h03;
        repeat (3) @(posedge clk_sys);
        chk("even off", 0, lines[0]);
        chk("odd off", 0, lines[1]);
        rst_n <= 0;
        @(posedge clk_sys);
        rst_n <= 1;
        xfer(0, 0, 0);
        chk("reset", ROUTE_CTRL_RESET, r);
        xfer(0, 32'h10, 0);
        chk("unmapped", 0, r);
        give_verdict;
    end
endmodule // tb_top
